// File: verilog/pcsr_consts.svh
`ifndef PCSR_CONSTS_SVH
`define PCSR_CONSTS_SVH

// ==========================================================
// configuration offsets
// ==========================================================
`define PCSR_CMD_OFFSET 8'h04
`define PCSR_STS_OFFSET 8'h06
`define PCSR_DWORD_OFFSET 8'h04

// ==========================================================
// reset values and masks
// ==========================================================
`define PCSR_CMD_RESET 16'h0000
`define PCSR_STS_RESET 16'h0210
`define PCSR_CMD_WR_MASK 16'h0156
`define PCSR_STS_FIXED 16'h0210
`define PCSR_STS_CLR_MASK 16'hF900

// ==========================================================
// command bit positions
// ==========================================================
`define PCSR_CMD_IO_BIT 0
`define PCSR_CMD_MEM_BIT 1
`define PCSR_CMD_INIT_BIT 2
`define PCSR_CMD_SPECIAL_BIT 3
`define PCSR_CMD_MWI_BIT 4
`define PCSR_CMD_SNOOP_BIT 5
`define PCSR_CMD_PERR_BIT 6
`define PCSR_CMD_STEP_BIT 7
`define PCSR_CMD_SERR_BIT 8
`define PCSR_CMD_B2B_BIT 9

// ==========================================================
// status bit positions
// ==========================================================
`define PCSR_STS_MASTER_DATA_PARITY_ERROR_BIT 8
`define PCSR_STS_TA_SIG_BIT 11
`define PCSR_STS_TA_REC_BIT 12
`define PCSR_STS_MA_REC_BIT 13
`define PCSR_STS_SYS_BIT 14
`define PCSR_STS_PAR_BIT 15

// number of sticky status flags
`define PCSR_STICKY_COUNT 6

`endif

// File: verilog/pcsr_pkg.sv
`default_nettype none

// ==========================================================
// shared types
// ==========================================================
package pcsr_pkg;

	// sticky flag order inside the flag bank
	typedef enum logic [2:0] {
		PCSR_FLG_MASTER_DATA_PARITY_ERROR = 3'h0,
		PCSR_FLG_TA_SIG = 3'h1,
		PCSR_FLG_TA_REC = 3'h2,
		PCSR_FLG_MA_REC = 3'h3,
		PCSR_FLG_SYS = 3'h4,
		PCSR_FLG_PAR = 3'h5
	} pcsr_flag_e;

	// state of the register bank
	typedef struct packed {
		logic [15:0] command; // command register image
		logic [31:0] rdata; // registered read data
		logic ack; // access answer
	} pcsr_state_s;

	// state of the sticky flag bank
	typedef struct packed {
		logic [5:0] flags; // sticky flags
	} pcsr_flags_s;

endpackage

`default_nettype wire

// File: verilog/pcsr_sticky_bits.sv
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// sticky write-one-to-clear flag bank
// ==========================================================
module pcsr_sticky_bits #(
	parameter int WIDTH = 6
) (
	input wire logic ref_clk_in,
	input wire logic rst_in,
	input wire logic [WIDTH-1:0] set_in, // hardware events
	input wire logic [WIDTH-1:0] clear_in, // software one-writes
	output logic [WIDTH-1:0] flags_out
);

	// registered state and its next copy
	pcsr_pkg::pcsr_flags_s state;
	pcsr_pkg::pcsr_flags_s next_state;
	logic [WIDTH-1:0] next_flags;

	// per bit: set wins over clear, zero writes keep the bit
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			assign next_flags[i] = set_in[i] | (state.flags[i] & ~clear_in[i]);
		end
	endgenerate

	// next state fill
	always_comb begin
		next_state = state;
		next_state.flags = next_flags;
	end

	// state register
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign flags_out = state.flags;

	// a colliding set and clear leaves the flag set
	a_set_wins_clear: assert property (
		@(posedge ref_clk_in) disable iff (rst_in)
		(set_in[0] && clear_in[0]) |=> flags_out[0])
		else $error("set lost against clear");

endmodule

`default_nettype wire

// File: verilog/pcsr_regs.sv

`timescale 1ns/100ps
`default_nettype none
`include "pcsr_consts.svh"

// ==========================================================
// command and status register bank
// ==========================================================
module pcsr_regs (
	input wire logic ref_clk_in,
	input wire logic rst_in,
	// configuration access port
	input wire logic cfg_rd_in, // read strobe
	input wire logic cfg_wr_in, // write strobe
	input wire logic [7:0] cfg_addr_in, // byte address
	input wire logic [3:0] cfg_be_in, // byte enables
	input wire logic [31:0] cfg_wdata_in, // write data
	output logic [31:0] cfg_rdata_out, // read data
	output logic cfg_ack_out, // answer pulse
	// requests from the bus-interface logic
	input wire logic bus_req_in, // wants the bus
	input wire logic want_write_invalidate_in, // wants mwi command
	input wire logic mem_cycle_hit_in, // memory decode hit
	input wire logic serr_req_in, // address parity error seen
	input wire logic perr_req_in, // data parity error seen
	// events from the bus-interface logic
	input wire logic addr_parity_err_in, // address parity error
	input wire logic data_parity_err_in, // data parity error
	input wire logic perr_sampled_in, // perr seen from any agent
	input wire logic own_master_phase_in, // device was master
	input wire logic master_abort_in, // master abort received
	input wire logic target_abort_rx_in, // target abort received
	input wire logic target_abort_tx_in, // target abort signaled
	// gated controls to the bus-interface logic
	output logic bus_req_out, // gated bus request
	output logic use_write_invalidate_out, // use mwi command
	output logic memory_claim_out, // claim memory cycle
	output logic io_claim_out, // claim io cycle
	output logic special_cycle_claim_out, // claim special cycle
	output logic back_to_back_enable_out, // fast back-to-back
	output logic stepping_enable_out, // address/data stepping
	output logic serr_drive_out, // drive system error
	output logic perr_drive_out // drive parity error
);

	// ==========================================================
	// state and decode
	// ==========================================================

	// registered state and its next copy
	pcsr_pkg::pcsr_state_s state;
	pcsr_pkg::pcsr_state_s next_state;

	// decoded access to the command/status word
	logic hit;
	logic cmd_wr_lo;
	logic cmd_wr_hi;
	logic sts_wr_lo;
	logic sts_wr_hi;

	// sticky flag bank wiring
	logic [5:0] flag_set;
	logic [5:0] flag_clear;
	logic [5:0] flags;

	// assembled register images
	logic [15:0] command;
	logic [15:0] status;
	logic [15:0] sts_clear;

	// command enables pulled out by name
	logic initiator_enable;
	logic memory_space_enable;
	logic write_invalidate_enable;
	logic parity_response_enable;
	logic system_error_drive_enable;

	// word address decode, offset 06h shares the word at 04h
	assign hit = (cfg_addr_in[7:2] == 6'(`PCSR_DWORD_OFFSET >> 2));

	// byte lanes 0..1 hold command, 2..3 hold status
	assign cmd_wr_lo = cfg_wr_in & hit & cfg_be_in[0];
	assign cmd_wr_hi = cfg_wr_in & hit & cfg_be_in[1];
	assign sts_wr_lo = cfg_wr_in & hit & cfg_be_in[2];
	assign sts_wr_hi = cfg_wr_in & hit & cfg_be_in[3];

	// ==========================================================
	// command register
	// ==========================================================

	// only writable bits ever hold a one
	assign command = state.command & `PCSR_CMD_WR_MASK;

	assign initiator_enable = command[`PCSR_CMD_INIT_BIT];
	assign memory_space_enable = command[`PCSR_CMD_MEM_BIT];
	assign write_invalidate_enable = command[`PCSR_CMD_MWI_BIT];
	assign parity_response_enable = command[`PCSR_CMD_PERR_BIT];
	assign system_error_drive_enable = command[`PCSR_CMD_SERR_BIT];

	// ==========================================================
	// status register
	// ==========================================================

	// one-writes on enabled lanes clear, zero-writes keep
	assign sts_clear = {cfg_wdata_in[31:24] & {8{sts_wr_hi}},
		cfg_wdata_in[23:16] & {8{sts_wr_lo}}} & `PCSR_STS_CLR_MASK;

	// event sources for each sticky flag
	always_comb begin
		flag_set = '0;
		// data parity only for own master phase with response on
		flag_set[pcsr_pkg::PCSR_FLG_MASTER_DATA_PARITY_ERROR] = perr_sampled_in & own_master_phase_in
			& parity_response_enable;
		flag_set[pcsr_pkg::PCSR_FLG_TA_SIG] = target_abort_tx_in;
		flag_set[pcsr_pkg::PCSR_FLG_TA_REC] = target_abort_rx_in;
		flag_set[pcsr_pkg::PCSR_FLG_MA_REC] = master_abort_in;
		flag_set[pcsr_pkg::PCSR_FLG_SYS] = serr_drive_out;
		flag_set[pcsr_pkg::PCSR_FLG_PAR] = addr_parity_err_in | data_parity_err_in;
	end

	// clear requests mapped onto the flag order
	always_comb begin
		flag_clear = '0;
		flag_clear[pcsr_pkg::PCSR_FLG_MASTER_DATA_PARITY_ERROR] = sts_clear[`PCSR_STS_MASTER_DATA_PARITY_ERROR_BIT];
		flag_clear[pcsr_pkg::PCSR_FLG_TA_SIG] = sts_clear[`PCSR_STS_TA_SIG_BIT];
		flag_clear[pcsr_pkg::PCSR_FLG_TA_REC] = sts_clear[`PCSR_STS_TA_REC_BIT];
		flag_clear[pcsr_pkg::PCSR_FLG_MA_REC] = sts_clear[`PCSR_STS_MA_REC_BIT];
		flag_clear[pcsr_pkg::PCSR_FLG_SYS] = sts_clear[`PCSR_STS_SYS_BIT];
		flag_clear[pcsr_pkg::PCSR_FLG_PAR] = sts_clear[`PCSR_STS_PAR_BIT];
	end

	// sticky flags, set wins against a same-cycle clear
	pcsr_sticky_bits #(
		.WIDTH(`PCSR_STICKY_COUNT)
	) u_flags (
		.ref_clk_in(ref_clk_in),
		.rst_in(rst_in),
		.set_in(flag_set),
		.clear_in(flag_clear),
		.flags_out(flags)
	);

	// status image: fixed bits plus sticky flags
	always_comb begin
		status = `PCSR_STS_FIXED;
		status[`PCSR_STS_MASTER_DATA_PARITY_ERROR_BIT] = flags[pcsr_pkg::PCSR_FLG_MASTER_DATA_PARITY_ERROR];
		status[`PCSR_STS_TA_SIG_BIT] = flags[pcsr_pkg::PCSR_FLG_TA_SIG];
		status[`PCSR_STS_TA_REC_BIT] = flags[pcsr_pkg::PCSR_FLG_TA_REC];
		status[`PCSR_STS_MA_REC_BIT] = flags[pcsr_pkg::PCSR_FLG_MA_REC];
		status[`PCSR_STS_SYS_BIT] = flags[pcsr_pkg::PCSR_FLG_SYS];
		status[`PCSR_STS_PAR_BIT] = flags[pcsr_pkg::PCSR_FLG_PAR];
	end

	// ==========================================================
	// next state
	// ==========================================================

	// command writes per byte lane, read data and answer
	always_comb begin
		next_state = state;
		// low command byte
		if (cmd_wr_lo) begin
			next_state.command[7:0] = cfg_wdata_in[7:0] & 8'(`PCSR_CMD_WR_MASK);
		end
		// high command byte, reserved bits dropped
		if (cmd_wr_hi) begin
			next_state.command[15:8] = cfg_wdata_in[15:8] & 8'(`PCSR_CMD_WR_MASK >> 8);
		end
		// reads return the word before any same-cycle write
		if (cfg_rd_in && hit) begin
			next_state.rdata = {status, command};
		end else if (cfg_rd_in) begin
			// unmapped offsets read as zero
			next_state.rdata = '0;
		end
		next_state.ack = cfg_rd_in | cfg_wr_in;
	end

	// state register
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			state.command <= `PCSR_CMD_RESET;
			state.rdata <= '0;
			state.ack <= 1'b0;
		end else begin
			state <= next_state;
		end
	end

	// ==========================================================
	// outputs to the bus-interface logic
	// ==========================================================

	assign cfg_rdata_out = state.rdata;
	assign cfg_ack_out = state.ack;

	// requests gated by the command enables; io, special, back-to-back and stepping are bare command bits
	assign bus_req_out = bus_req_in & initiator_enable;
	assign use_write_invalidate_out = want_write_invalidate_in & write_invalidate_enable;
	assign memory_claim_out = mem_cycle_hit_in & memory_space_enable;
	assign io_claim_out = command[`PCSR_CMD_IO_BIT];
	assign special_cycle_claim_out = command[`PCSR_CMD_SPECIAL_BIT];
	assign back_to_back_enable_out = command[`PCSR_CMD_B2B_BIT];
	assign stepping_enable_out = command[`PCSR_CMD_STEP_BIT];
	assign serr_drive_out = serr_req_in & system_error_drive_enable;
	assign perr_drive_out = perr_req_in & parity_response_enable;

	// ==========================================================
	// checks
	// ==========================================================

	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (rst_in);

	// any hardware event that can touch a status flag
	logic any_event;
	assign any_event = |flag_set;

	// read-only command bits never read one
	a_cmd_ro_zero: assert property (
		(command[15:9] == 7'h00) && !command[7] && !command[5] && !command[3] && !command[0])
		else $error("read-only command bit is set");

	// a full command write lands masked one cycle later
	a_cmd_write_lands: assert property (
		(cmd_wr_lo && cmd_wr_hi) |=> (command == ($past(cfg_wdata_in[15:0]) & `PCSR_CMD_WR_MASK)))
		else $error("command write not stored");

	// system error only with its enable
	a_serr_gated: assert property (
		serr_drive_out |-> command[`PCSR_CMD_SERR_BIT])
		else $error("system error driven while disabled");

	// parity error only with its enable
	a_perr_gated: assert property (
		perr_drive_out |-> command[`PCSR_CMD_PERR_BIT])
		else $error("parity error driven while disabled");

	// write-invalidate only with its enable
	a_mwi_gated: assert property (
		use_write_invalidate_out |-> command[`PCSR_CMD_MWI_BIT])
		else $error("write-invalidate used while disabled");

	// bus request only with initiator enable
	a_req_gated: assert property (
		bus_req_out |-> command[`PCSR_CMD_INIT_BIT])
		else $error("bus requested while initiator disabled");

	// memory cycles claimed only when enabled
	a_mem_gated: assert property (
		(mem_cycle_hit_in && !command[`PCSR_CMD_MEM_BIT]) |-> !memory_claim_out)
		else $error("memory cycle claimed while disabled");

	// no io, special cycle, stepping or back-to-back
	a_never_claims: assert property (
		!io_claim_out && !special_cycle_claim_out && !stepping_enable_out && !back_to_back_enable_out)
		else $error("unsupported feature enabled");

	// status resets to its documented value
	a_sts_reset: assert property (
		$past(rst_in) |-> (status == `PCSR_STS_RESET))
		else $error("status reset value wrong");

	// zero writes with no event keep status
	a_sts_zero_keeps: assert property (
		(cfg_wr_in && hit && cfg_wdata_in[31:16] == 16'h0000 && !any_event) |=> $stable(status))
		else $error("zero write changed status");

	// a one-write with no event clears the flag
	a_sts_one_clears: assert property (
		(sts_wr_hi && cfg_wdata_in[31] && !any_event) |=> !status[`PCSR_STS_PAR_BIT])
		else $error("one write did not clear");

	// any parity error sets bit 15
	a_par_sets: assert property (
		(addr_parity_err_in || data_parity_err_in) |=> status[`PCSR_STS_PAR_BIT])
		else $error("parity error not recorded");

	// driven system error sets bit 14
	a_sys_sets: assert property (
		serr_drive_out |=> status[`PCSR_STS_SYS_BIT])
		else $error("system error not recorded");

	// master abort sets bit 13
	a_ma_sets: assert property (
		master_abort_in |=> status[`PCSR_STS_MA_REC_BIT])
		else $error("master abort not recorded");

	// received target abort sets bit 12
	a_ta_rec_sets: assert property (
		target_abort_rx_in |=> status[`PCSR_STS_TA_REC_BIT])
		else $error("received target abort not recorded");

	// signaled target abort sets bit 11
	a_ta_sig_sets: assert property (
		target_abort_tx_in |=> status[`PCSR_STS_TA_SIG_BIT])
		else $error("signaled target abort not recorded");

	// hardwired status bits hold their values
	a_sts_fixed: assert property (
		(status[10:9] == 2'h1) && (status[7:5] == 3'h0) && status[4] && (status[3:0] == 4'h0))
		else $error("hardwired status bits wrong");

	// bit 8 rises only on all three conditions
	a_master_data_parity_error_cause: assert property (
		$rose(status[`PCSR_STS_MASTER_DATA_PARITY_ERROR_BIT]) |->
		$past(perr_sampled_in && own_master_phase_in && command[`PCSR_CMD_PERR_BIT]))
		else $error("data parity flag set without cause");

	// an event beats a same-cycle clear
	a_event_beats_clear: assert property (
		(master_abort_in && sts_wr_hi && cfg_wdata_in[29]) |=> status[`PCSR_STS_MA_REC_BIT])
		else $error("event lost to clear");

	// read answers one cycle later with the status half of the word
	a_read_answer: assert property (
		(cfg_rd_in && hit) |=> (cfg_ack_out && cfg_rdata_out[31:16] == $past(status)))
		else $error("read answer wrong");

endmodule

`default_nettype wire

// File: tb/pcsr_host_model.sv
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// host side: configuration cycles into the register bank
// ==========================================================
module pcsr_host_model (
	input wire logic ref_clk_in,
	output logic cfg_rd_out,
	output logic cfg_wr_out,
	output logic [7:0] cfg_addr_out,
	output logic [3:0] cfg_be_out,
	output logic [31:0] cfg_wdata_out
);
	// quiet bus from time zero
	initial begin
		cfg_rd_out = 1'b0;
		cfg_wr_out = 1'b0;
		cfg_addr_out = 8'h00;
		cfg_be_out = 4'h0;
		cfg_wdata_out = 32'h0;
	end

	// one access: strobe for one cycle, then scramble the released lines
	// so a design that samples them late sees garbage, not a stale copy
	task automatic access(input logic rd, input logic [7:0] addr, input logic [3:0] be, input logic [31:0] data);
		@(posedge ref_clk_in);
		cfg_rd_out <= rd;
		cfg_wr_out <= ~rd;
		cfg_addr_out <= addr;
		cfg_be_out <= be;
		cfg_wdata_out <= data;
		@(posedge ref_clk_in);
		cfg_rd_out <= 1'b0;
		cfg_wr_out <= 1'b0;
		cfg_addr_out <= ~addr;
		cfg_be_out <= ~be;
		cfg_wdata_out <= ~data;
	endtask
endmodule

`default_nettype wire

// File: tb/testbench.sv
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// self-checking bench for the command and status bank
// ==========================================================
module testbench;
	logic ref_clk_in = 1'b0; // 25 MHz clock
	logic rst_in = 1'b1; // synchronous reset
	logic cfg_rd, cfg_wr, cfg_ack; // access strobes and answer
	logic [7:0] cfg_addr; // byte address
	logic [3:0] cfg_be; // byte enables
	logic [31:0] cfg_wdata, cfg_rdata; // data both ways
	logic [4:0] g = 5'h00; // bus_req, wwi, mem_hit, serr_req, perr_req
	logic [4:0] gout; // gated controls in the same order
	logic [3:0] zout; // io, special, back-to-back, stepping
	logic [7:0] ev = 8'h00; // event pulses
	logic [15:0] cmd_e = 16'h0000; // expected command image
	logic [32:0] exp_q[$]; // {is_read, expected data}
	logic [32:0] e_m; // oldest note
	int n_errors = 0;
	int checks = 0;
	int cycles = 0;
	logic [7:0] ev_tab [7] = '{8'h01, 8'h02, 8'h0C, 8'h10, 8'h20, 8'h40, 8'h80};
	logic [15:0] bit_tab [7] = '{16'h8000, 16'h8000, 16'h0100, 16'h2000, 16'h1000, 16'h0800, 16'h4000};

	// ==========================================================
	// clock, partner and design
	// ==========================================================
	always #20 ref_clk_in = ~ref_clk_in;

	pcsr_host_model u_host (.ref_clk_in(ref_clk_in), .cfg_rd_out(cfg_rd), .cfg_wr_out(cfg_wr),
		.cfg_addr_out(cfg_addr), .cfg_be_out(cfg_be), .cfg_wdata_out(cfg_wdata));

	pcsr_regs u_dut (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .cfg_rd_in(cfg_rd), .cfg_wr_in(cfg_wr),
		.cfg_addr_in(cfg_addr), .cfg_be_in(cfg_be), .cfg_wdata_in(cfg_wdata), .cfg_rdata_out(cfg_rdata),
		.cfg_ack_out(cfg_ack), .bus_req_in(g[4]), .want_write_invalidate_in(g[3]), .mem_cycle_hit_in(g[2]),
		.serr_req_in(g[1] | ev[7]), .perr_req_in(g[0]), .addr_parity_err_in(ev[0]),
		.data_parity_err_in(ev[1]), .perr_sampled_in(ev[2]), .own_master_phase_in(ev[3]),
		.master_abort_in(ev[4]), .target_abort_rx_in(ev[5]), .target_abort_tx_in(ev[6]),
		.bus_req_out(gout[4]), .use_write_invalidate_out(gout[3]), .memory_claim_out(gout[2]),
		.serr_drive_out(gout[1]), .perr_drive_out(gout[0]), .io_claim_out(zout[3]),
		.special_cycle_claim_out(zout[2]), .back_to_back_enable_out(zout[1]), .stepping_enable_out(zout[0]));

	// ==========================================================
	// helpers
	// ==========================================================
	// compare and count
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] expv);
		checks++;
		if (seen !== expv) begin
			n_errors++;
			$display("Error %s expected %h seen %h", what, expv, seen);
		end
	endtask

	// counts, verdict, stop
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// read with a noted expectation
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back({1'b1, e});
		u_host.access(1'b1, a, 4'hF, 32'h0);
	endtask

	// write, noting only that an answer is due
	task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
		exp_q.push_back({1'b0, 32'h0});
		u_host.access(1'b0, a, be, d);
	endtask

	// one-cycle event pulse
	task automatic pulse(input logic [7:0] p);
		@(posedge ref_clk_in);
		ev <= p;
		@(posedge ref_clk_in);
		ev <= 8'h00;
	endtask

	// random requests against the current enables
	task automatic gates();
		repeat (8) begin
			@(posedge ref_clk_in);
			g <= 5'($urandom);
			@(negedge ref_clk_in);
			check("gated", 32'(gout), 32'(g & {cmd_e[2], cmd_e[4], cmd_e[1], cmd_e[8], cmd_e[6]}));
			check("fixed zero", 32'(zout), 32'h0);
		end
		@(posedge ref_clk_in);
		g <= 5'h00;
	endtask

	// ==========================================================
	// answer watcher and hang guard
	// ==========================================================
	always @(posedge ref_clk_in) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			n_errors++;
			end_of_test();
		end else if (cfg_ack === 1'b1) begin
			if (exp_q.size() == 0) begin
				check("spare answer", 32'h1, 32'h0);
			end else begin
				e_m = exp_q.pop_front();
				if (e_m[32]) begin
					check("read data", cfg_rdata, e_m[31:0]);
				end
			end
		end
	end

	// ==========================================================
	// main sequence
	// ==========================================================
	initial begin
		void'($urandom(32'hBE19));
		repeat (2) @(posedge ref_clk_in);
		rst_in <= 1'b0;
		rd(8'h04, 32'h0210_0000);
		gates();
		$display("test reset done");
		// all ones into the command lanes; only the writable bits 0156h stick
		wr(8'h04, 4'h3, 32'h0000_FFFF);
		cmd_e = 16'h0156;
		rd(8'h04, 32'h0210_0156);
		gates();
		wr(8'h04, 4'hC, 32'hFFFF_0000);
		rd(8'h04, 32'h0210_0156);
		$display("test command done");
		// each event sets its flag; zero writes keep it, one clears it
		for (int i = 0; i < 7; i++) begin
			pulse(ev_tab[i]);
			wr(8'h04, 4'hC, 32'h0000_0000);
			rd(8'h04, {16'h0210 | bit_tab[i], 16'h0156});
			wr(8'h04, 4'hC, {bit_tab[i], 16'h0000});
			rd(8'h04, 32'h0210_0156);
		end
		$display("test events done");
		// events and clears meet in one cycle: parity, master abort, data parity
		fork
			wr(8'h04, 4'hC, 32'hA100_0000);
			pulse(8'h1D);
		join
		rd(8'h04, 32'hA310_0156);
		wr(8'h04, 4'hC, 32'hA100_0000);
		pulse(8'h04);
		rd(8'h04, 32'h0210_0156);
		$display("test priority done");
		// lane 0 alone, then lane 1: enables off one by one
		wr(8'h04, 4'h1, 32'hFFFF_FF00);
		cmd_e = 16'h0100;
		pulse(8'h0C);
		rd(8'h04, 32'h0210_0100);
		wr(8'h04, 4'h2, 32'h0000_0000);
		pulse(8'h80);
		rd(8'h04, 32'h0210_0000);
		// other addresses take no write and read zero
		wr(8'h08, 4'hF, 32'hFFFF_FFFF);
		rd(8'h04, 32'h0210_0000);
		rd(8'h08, 32'h0000_0000);
		$display("test lanes done");
		repeat (3) @(posedge ref_clk_in);
		check("pending answers", 32'(exp_q.size()), 32'h0);
		end_of_test();
	end
endmodule

`default_nettype wire
